// File: testbench/cache_miss_op_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cache_miss_op_sequencer_tb;
    import miss_seq_pkg::*;
    logic clk, srst, im, ims, dm, dms, op, oh, od, sf, rf, vp, db, lw, rx, wbf, ext;
    logic ia, da, oa, wr, fw, pk, st, dn;
    logic [RATIO_W-1:0] ratio;
    logic [LAT_W-1:0] lp, rp, lat, ret;
    logic [OP_W-1:0] code;
    int error_cnt, comparisons, n, base, r, t;
    logic fl, pks;
    int q[$];
    // ====
    // design, agent model
    cache_miss_op_sequencer cache_miss_op_sequencer_i (.i_sys_clk(clk), .i_srst(srst), .i_clock_ratio(ratio),
        .i_memory_latency_cycles(lat), .i_block_return_cycles(ret), .i_imiss_req(im), .i_imiss_sc_hit(ims),
        .i_dmiss_req(dm), .i_dmiss_sc_hit(dms), .i_op_req(op), .i_op_code(code), .i_op_hit(oh), .i_op_dirty(od),
        .i_wb_buf_full(wbf), .i_ext_req_pend(ext), .i_store_buf_full(sf), .i_resp_buf_full(rf),
        .i_victim_pend(vp), .i_dcache_busy(db), .o_imiss_ack(ia), .o_dmiss_ack(da), .o_op_ack(oa),
        .o_wb_retire_req(wr), .o_fills_wb(fw), .o_resp_park(pk), .o_stall(st), .o_done(dn));
    ext_agent_model ext_agent_model_i (.i_sys_clk(clk), .i_srst(srst), .i_wb_retire_req(wr), .i_load_wb(lw),
        .i_raise_ext(rx), .i_lat_pick(lp), .i_ret_pick(rp), .o_wb_buf_full(wbf), .o_ext_req_pend(ext),
        .o_memory_latency_cycles(lat), .o_block_return_cycles(ret));
    always #50 clk = ~clk;
    // ====
    // reference model of cycle counts
    function automatic int exp_op(int c, int h, int d);
        case (c)
            0: return d ? 12 : 10;
            1: return 7;
            2: return 8;
            3: return h ? 10 : (d ? 15 : 13);
            4: return h ? 9 : 7;
            5: return !h ? 7 : (d ? 14 : 12);
            default: return !h ? 7 : (d ? 14 : 10);
        endcase
    endfunction : exp_op
    // fixed part of a miss; head plus alignment adds 1..ratio on top
    function automatic int miss_base(int ic, int hit, int rr, int l, int b);
        if (ic) return hit ? 6 * rr + 3 : (2 + l + b) * rr + 3;
        return hit ? 3 * rr + 2 : (3 + l) * rr + 2;
    endfunction : miss_base
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic timed_out();
        error_cnt++;
        $display("[FAIL] wait expected done seen timeout");
        end_sim();
    endtask : timed_out
    // one request held until taken, stall cycles counted until done
    task automatic run(input int kind, output int cnt, output logic f);
        cnt = 0;
        f = 1'b0;
        @(posedge clk);
        im <= (kind == 1);
        dm <= (kind == 2);
        op <= (kind == 3);
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while ((ia | da | oa) !== 1'b1 && t < 3000);
        if (t >= 3000) timed_out();
        @(posedge clk);
        {im, dm, op, sf, rf} <= 5'h00;
        for (t = 0; dn !== 1'b1; t++) begin
            @(negedge clk);
            if (t > 3000) timed_out();
            if (st === 1'b1) cnt++;
            f = f | fw;
        end
    endtask : run
    // ====
    // main sequence
    initial begin
        {clk, im, ims, dm, dms, op, oh, od, sf, rf, vp, db, lw, rx} = '0;
        srst = 1'b1;
        ratio = 4'h2;
        code = 3'h0;
        lp = 6'h03;
        rp = 6'h04;
        error_cnt = 0;
        comparisons = 0;
        void'($urandom(40080));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        // every op code with every hit and dirty case
        for (int c = 0; c < 7; c++) for (int h = 0; h < 2; h++) for (int d = 0; d < 2; d++) begin
            @(posedge clk);
            code <= c[2:0];
            oh <= h[0];
            od <= d[0];
            run(3, n, fl);
            check("op cycles", n, exp_op(c, h, d));
            check("op fills wb", fl, (c == 0 && d) || (c == 3 && !h && d) || (c > 4 && h && d));
        end
        $display("test op table finished");
        // drain of store then response buffer before a data op
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            code <= 3'h1;
            sf <= (k == 0);
            rf <= (k == 1);
            run(3, n, fl);
            check("op drain cycles", n, 10);
        end
        $display("test drain finished");
        // misses over every ratio with random latency and return
        for (int i = 0; i < 14; i++) begin
            @(posedge clk);
            r = 2 + i % 7;
            ratio <= r[3:0];
            lp <= 6'(3 + $urandom_range(7));
            rp <= 6'(1 + $urandom_range(3));
            ims <= 1'($urandom_range(1));
            dms <= ims;
            @(posedge clk);
            run(1 + i % 2, n, fl);
            base = miss_base(i % 2 == 0, (i % 2 == 0) ? ims : dms, r, lat, ret);
            check("miss stall in range", (n > base && n <= base + r), 1);
        end
        $display("test misses finished");
        // data miss with victim move and busy cache: only longer
        @(posedge clk);
        vp <= 1'b1;
        db <= 1'b1;
        dms <= 1'b1;
        fork
            run(2, n, fl);
            begin
                pks = 1'b0;
                repeat (60) begin
                    @(negedge clk);
                    pks = pks | (pk === 1'b1);
                end
                @(posedge clk);
                vp <= 1'b0;
                db <= 1'b0;
            end
        join
        check("parked miss not short", n > miss_base(0, 1, r, lat, ret) + r, 1);
        check("park seen", pks, 1'b1);
        $display("test park finished");
        // all three jobs behind a write-back and an external request
        @(posedge clk);
        lw <= 1'b1;
        rx <= 1'b1;
        @(posedge clk);
        {lw, rx} <= 2'b00;
        {im, dm, op} <= 3'b111;
        code <= 3'h2;
        fl = 1'b0;
        for (t = 0; q.size() < 3 && t < 5000; t++) begin
            @(negedge clk);
            if (ia === 1'b1) q.push_back(1);
            if (da === 1'b1) q.push_back(2);
            if (oa === 1'b1) q.push_back(3);
            if (wr === 1'b1) fl = 1'b1;
            @(posedge clk);
            im <= im && !(q.size() > 0 && q[$] == 1);
            dm <= dm && !(q.size() > 0 && q[$] == 2);
            op <= op && !(q.size() > 0 && q[$] == 3);
        end
        if (q.size() < 3) timed_out();
        check("ack order", q[0] * 100 + q[1] * 10 + q[2], 123);
        check("retire asked", fl, 1'b1);
        for (t = 0; dn !== 1'b1 && t < 500; t++) @(negedge clk);
        if (t >= 500) timed_out();
        $display("test priority finished");
        end_sim();
    end
endmodule : cache_miss_op_sequencer_tb
bind cache_miss_op_sequencer miss_seq_chk miss_seq_chk_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_imiss_req(i_imiss_req), .i_dmiss_req(i_dmiss_req), .i_wb_buf_full(i_wb_buf_full),
    .i_ext_req_pend(i_ext_req_pend), .o_imiss_ack(o_imiss_ack), .o_dmiss_ack(o_dmiss_ack), .o_op_ack(o_op_ack),
    .o_wb_retire_req(o_wb_retire_req), .o_resp_park(o_resp_park), .o_stall(o_stall), .o_done(o_done));
`default_nettype wire

// File: testbench/ext_agent_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// system agent: write-back drain, external requests, bus timing
module ext_agent_model
    import miss_seq_pkg::*;
(
    // clock and reset
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_srst,
    // retire request from the sequencer, stimulus from the bench
    input  wire logic                           i_wb_retire_req,
    input  wire logic                           i_load_wb,
    input  wire logic                           i_raise_ext,
    input  wire logic [miss_seq_pkg::LAT_W-1:0] i_lat_pick,
    input  wire logic [miss_seq_pkg::LAT_W-1:0] i_ret_pick,
    // towards the sequencer
    output logic                                o_wb_buf_full,
    output logic                                o_ext_req_pend,
    output logic [miss_seq_pkg::LAT_W-1:0]      o_memory_latency_cycles,
    output logic [miss_seq_pkg::LAT_W-1:0]      o_block_return_cycles
);
    int wb_cnt;
    int ext_cnt;
    // floor of three lets the secondary lookup finish first
    assign o_memory_latency_cycles = (i_lat_pick < 6'h03) ? 6'h03 : i_lat_pick;
    assign o_block_return_cycles = (i_ret_pick == 6'h00) ? 6'h01 : i_ret_pick;
    // memory write of the buffer is slow, external request fixed length
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_wb_buf_full <= 1'b0;
            o_ext_req_pend <= 1'b0;
            wb_cnt <= 0;
            ext_cnt <= 0;
        end else begin
            if (i_load_wb) o_wb_buf_full <= 1'b1;
            else if (o_wb_buf_full && i_wb_retire_req) begin
                wb_cnt <= (wb_cnt == 4) ? 0 : wb_cnt + 1;
                if (wb_cnt == 4) o_wb_buf_full <= 1'b0;
            end
            if (i_raise_ext) o_ext_req_pend <= 1'b1;
            else if (o_ext_req_pend) begin
                ext_cnt <= (ext_cnt == 6) ? 0 : ext_cnt + 1;
                if (ext_cnt == 6) o_ext_req_pend <= 1'b0;
            end
        end
    end
endmodule : ext_agent_model
`default_nettype wire

// File: testbench/miss_seq_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// ordering and stall checks at the sequencer ports
module miss_seq_chk (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // requests and neighbour status
    input wire logic i_imiss_req,
    input wire logic i_dmiss_req,
    input wire logic i_wb_buf_full,
    input wire logic i_ext_req_pend,
    // sequencer outputs
    input wire logic o_imiss_ack,
    input wire logic o_dmiss_ack,
    input wire logic o_op_ack,
    input wire logic o_wb_retire_req,
    input wire logic o_resp_park,
    input wire logic o_stall,
    input wire logic o_done
);
    // op bound leaves room for retire and external waits
    localparam int OP_MIN = 8;
    localparam int OP_MAX = 400;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);
    // acceptance and the shortest busy span of an op
    sequence s_any_ack;
        o_imiss_ack || o_dmiss_ack || o_op_ack;
    endsequence
    sequence s_busy7;
        o_stall [*7];
    endsequence
    chk_imiss_wins: assert property (o_dmiss_ack |-> !i_imiss_req)
        else $error("data miss taken while instruction miss waits");
    chk_op_ranks_last: assert property (o_op_ack |-> !i_imiss_req && !i_dmiss_req)
        else $error("cache op taken ahead of a miss");
    chk_ack_onehot: assert property ($onehot0({o_imiss_ack, o_dmiss_ack, o_op_ack}))
        else $error("two jobs accepted together");
    chk_busy_no_ack: assert property (o_stall |-> !(o_imiss_ack || o_dmiss_ack || o_op_ack))
        else $error("job accepted while busy");
    chk_ack_stall: assert property (s_any_ack |=> o_stall)
        else $error("no stall after acceptance");
    chk_op_min_busy: assert property (o_op_ack |=> s_busy7)
        else $error("cache op shorter than seven cycles");
    chk_dmiss_min: assert property (o_dmiss_ack |=> o_stall [*8])
        else $error("data miss stall too short");
    chk_op_ends: assert property (o_op_ack |-> ##[OP_MIN:OP_MAX] o_done)
        else $error("cache op never completed");
    chk_done_edge: assert property (o_done |-> $fell(o_stall))
        else $error("done without stall release");
    chk_wb_first: assert property (o_stall && i_wb_buf_full |-> o_wb_retire_req)
        else $error("write-back buffer not retired first");
    chk_done_clear: assert property (o_done |-> !i_wb_buf_full && !i_ext_req_pend)
        else $error("job finished ahead of write-back or external request");
    chk_park_busy: assert property (o_resp_park |-> o_stall)
        else $error("response park outside a miss");
endmodule : miss_seq_chk
`default_nettype wire

// File: verilog/cache_miss_op_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - clock ratio two to eight; all counts in processor cycles
// - wait zero to ratio minus one cycles for the system clock edge
// - retire a non-empty write-back buffer before a data miss
// - instruction miss beats a data miss raised in the same cycle
// - finish pending external requests before a data miss
// - returned data waits for empty store/response buffers and victim move
// - early first doubleword parks in response buffer one or two cycles
// - data miss stall: 1+align+3r+2 hit, 1+align+(2+lat+1)r+2 miss
// - instruction miss stall: 1+align+6r+3 hit, 1+align+(2+lat+ret)r+3 miss
// - instruction miss waits for write-back retire and external requests
// - cache ops wait for write-back retire and external requests
// - instruction miss before cache op; cache op never overlaps data miss
// - data cache op waits buffer drain, adding three cycles if non-empty
// - writeback ops may load write-back buffer; later users stall
// - op 0 10/12, op 1 7, op 2 8 cycles
// - op 3 10 hit, 13 clean miss, 15 dirty miss
// - op 4 7 miss, 9 hit
// - op 5 7 miss, 12 clean hit, 14 dirty hit
// - op 6 7 miss, 10 clean hit, 14 dirty hit
module cache_miss_op_sequencer (
    // clock and reset
    input  wire logic                               i_sys_clk,
    input  wire logic                               i_srst,
    // configuration
    input  wire logic [miss_seq_pkg::RATIO_W-1:0]   i_clock_ratio,
    input  wire logic [miss_seq_pkg::LAT_W-1:0]     i_memory_latency_cycles,
    input  wire logic [miss_seq_pkg::LAT_W-1:0]     i_block_return_cycles,
    // miss requests, held until accepted
    input  wire logic                               i_imiss_req,
    input  wire logic                               i_imiss_sc_hit,
    input  wire logic                               i_dmiss_req,
    input  wire logic                               i_dmiss_sc_hit,
    // cache op request, held until accepted
    input  wire logic                               i_op_req,
    input  wire logic [miss_seq_pkg::OP_W-1:0]      i_op_code,
    input  wire logic                               i_op_hit,
    input  wire logic                               i_op_dirty,
    // state of neighbouring buffers
    input  wire logic                               i_wb_buf_full,
    input  wire logic                               i_ext_req_pend,
    input  wire logic                               i_store_buf_full,
    input  wire logic                               i_resp_buf_full,
    input  wire logic                               i_victim_pend,
    input  wire logic                               i_dcache_busy,
    // acceptance and status
    output logic                                    o_imiss_ack,
    output logic                                    o_dmiss_ack,
    output logic                                    o_op_ack,
    output logic                                    o_wb_retire_req,
    output logic                                    o_fills_wb,
    output logic                                    o_resp_park,
    output logic                                    o_stall,
    output logic                                    o_done
);
    import miss_seq_pkg::*;

    // ===========================================================
    // state
    // ===========================================================
    typedef struct packed {
        seq_state_type       st;
        job_type             job;
        logic                sc_hit;
        logic [CNT_W-1:0]    cnt;
        logic [CNT_W-1:0]    park;
        logic                fill_wb;
        logic                done;
    } seq_type;

    seq_type s_q;
    seq_type s_d;

    logic                sys_edge;
    logic [RATIO_W-1:0]  phase;
    logic [CNT_W-1:0]    op_cycles;
    logic                op_fills;
    logic [CNT_W-1:0]    ratio_w;
    logic [CNT_W-1:0]    miss_cnt;
    logic [CNT_W-1:0]    lat_mult;
    logic                buf_busy;
    logic                dside;

    // ===========================================================
    // helpers
    // ===========================================================
    sys_clk_phase u_phase (
        .i_sys_clk     (i_sys_clk),
        .i_srst        (i_srst),
        .i_clock_ratio (i_clock_ratio),
        .o_sys_edge    (sys_edge),
        .o_phase       (phase)
    );

    op_cycle_lut u_lut (
        .i_op_code  (i_op_code),
        .i_op_hit   (i_op_hit),
        .i_op_dirty (i_op_dirty),
        .o_cycles   (op_cycles),
        .o_fills_wb (op_fills)
    );

    // ===========================================================
    // miss count after the alignment point
    // ===========================================================
    // head cycle and alignment are spent in ST_ALIGN; the two wait-state cycles are taken off the rest
    always_comb begin
        ratio_w  = CNT_W'(i_clock_ratio);
        lat_mult = CNT_W'(MISS_ADDR_MULT) + CNT_W'(i_memory_latency_cycles);
        miss_cnt = CNT_ZERO;
        unique case (s_q.job)
            JOB_DMISS: begin
                if (s_q.sc_hit) begin
                    miss_cnt = CNT_W'(ratio_w * CNT_W'(DMISS_SC_HIT_MULT)) + DMISS_TAIL - WAIT_CYCLES;
                end else begin
                    miss_cnt = CNT_W'(ratio_w * (lat_mult + CNT_W'(DMISS_RET_MULT)))
                             + DMISS_TAIL - WAIT_CYCLES;
                end
            end
            JOB_IMISS: begin
                if (s_q.sc_hit) begin
                    miss_cnt = CNT_W'(ratio_w * CNT_W'(IMISS_SC_HIT_MULT)) + IMISS_TAIL - WAIT_CYCLES;
                end else begin
                    miss_cnt = CNT_W'(ratio_w * (lat_mult + CNT_W'(i_block_return_cycles)))
                             + IMISS_TAIL - WAIT_CYCLES;
                end
            end
            default: miss_cnt = CNT_ZERO;
        endcase
    end

    assign buf_busy = i_store_buf_full || i_resp_buf_full;
    assign dside    = (s_q.job == JOB_DMISS) || (s_q.job == JOB_CACHEOP);

    // ===========================================================
    // sequencer
    // ===========================================================
    // one job at a time, so a cache op and a data miss can never overlap
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        o_imiss_ack = 1'b0;
        o_dmiss_ack = 1'b0;
        o_op_ack    = 1'b0;
        unique case (s_q.st)
            ST_IDLE: begin
                // instruction miss first, then data miss, then cache op
                if (i_imiss_req) begin
                    s_d.job     = JOB_IMISS;
                    s_d.sc_hit  = i_imiss_sc_hit;
                    s_d.st      = ST_WBRET;
                    o_imiss_ack = 1'b1;
                end else if (i_dmiss_req) begin
                    s_d.job     = JOB_DMISS;
                    s_d.sc_hit  = i_dmiss_sc_hit;
                    s_d.st      = ST_WBRET;
                    o_dmiss_ack = 1'b1;
                end else if (i_op_req) begin
                    s_d.job     = JOB_CACHEOP;
                    // buffer state at acceptance decides the drain penalty
                    s_d.cnt     = op_cycles - WAIT_CYCLES + (buf_busy ? DRAIN_CYCLES : CNT_ZERO);
                    s_d.fill_wb = op_fills;
                    s_d.st      = ST_WBRET;
                    o_op_ack    = 1'b1;
                end
            end
            ST_WBRET: begin
                // write-back buffer, including one loaded by an earlier op
                if (!i_wb_buf_full) begin
                    s_d.st = ST_EXT;
                end
            end
            ST_EXT: begin
                if (!i_ext_req_pend) begin
                    if (s_q.job == JOB_CACHEOP) begin
                        s_d.st  = buf_busy ? ST_DRAIN : ST_COUNT;
                    end else begin
                        s_d.st  = ST_ALIGN;
                    end
                end
            end
            ST_DRAIN: begin
                // cache op waits out store and response buffers
                if (!buf_busy) begin
                    s_d.st = ST_COUNT;
                end
            end
            ST_ALIGN: begin
                // head cycle plus wait for the next system clock edge
                if (sys_edge) begin
                    s_d.st   = ST_COUNT;
                    s_d.cnt  = miss_cnt;
                    s_d.park = CNT_ZERO;
                end
            end
            ST_COUNT: begin
                // returned data held while data side is not ready
                if (s_q.job == JOB_DMISS && (buf_busy || i_victim_pend)
                        && s_q.cnt <= DMISS_TAIL) begin
                    s_d.park = s_q.park + CNT_ONE;
                end else if (s_q.job == JOB_DMISS && i_dcache_busy
                        && s_q.cnt == DMISS_TAIL && s_q.park < DMISS_TAIL) begin
                    s_d.park = s_q.park + CNT_ONE;
                end else if (s_q.cnt <= CNT_ONE) begin
                    s_d.st   = ST_IDLE;
                    s_d.job  = JOB_NONE;
                    s_d.done = 1'b1;
                    s_d.cnt  = CNT_ZERO;
                end else begin
                    s_d.cnt = s_q.cnt - CNT_ONE;
                end
            end
            default: begin
                s_d.st  = ST_IDLE;
                s_d.job = JOB_NONE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            s_q <= '{st: ST_IDLE, job: JOB_NONE, sc_hit: 1'b0, cnt: CNT_ZERO,
                     park: CNT_ZERO, fill_wb: 1'b0, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ===========================================================
    // outputs
    // ===========================================================
    // stall covers every busy state; release is the cycle after the last count
    assign o_stall         = (s_q.st != ST_IDLE);
    assign o_done          = s_q.done;
    assign o_wb_retire_req = (s_q.st == ST_WBRET) && i_wb_buf_full;
    assign o_fills_wb      = s_q.done ? 1'b0 : (s_q.job == JOB_CACHEOP && s_q.fill_wb);
    assign o_resp_park     = dside && (s_q.park != CNT_ZERO) && (s_q.st == ST_COUNT);
endmodule : cache_miss_op_sequencer
`default_nettype wire

// File: verilog/miss_seq_pkg.sv
`default_nettype none
package miss_seq_pkg;
    // clock ratio range, processor cycles per system cycle
    localparam int unsigned RATIO_MIN          = 2;
    localparam int unsigned RATIO_MAX          = 8;
    localparam int unsigned RATIO_W            = 4;
    localparam int unsigned LAT_W              = 6;
    localparam int unsigned CNT_W              = 10;
    localparam int unsigned OP_W               = 3;
    localparam int unsigned MIN_MEM_LATENCY    = 3;
    // miss equation pieces
    localparam logic [CNT_W-1:0] MISS_HEAD     = 10'h001;
    localparam logic [CNT_W-1:0] DMISS_TAIL    = 10'h002;
    localparam logic [CNT_W-1:0] IMISS_TAIL    = 10'h003;
    localparam logic [RATIO_W-1:0] DMISS_SC_HIT_MULT = 4'h3;
    localparam logic [RATIO_W-1:0] IMISS_SC_HIT_MULT = 4'h6;
    localparam logic [LAT_W-1:0] MISS_ADDR_MULT      = 6'h02;
    localparam logic [LAT_W-1:0] DMISS_RET_MULT      = 6'h01;
    localparam logic [CNT_W-1:0] DRAIN_CYCLES        = 10'h003;
    // write-back and external wait states stall one cycle each even when idle
    localparam logic [CNT_W-1:0] WAIT_CYCLES         = 10'h002;
    // data cache op codes
    localparam logic [OP_W-1:0] OP_IDX_WB_INV  = 3'h0;
    localparam logic [OP_W-1:0] OP_IDX_LD_TAG  = 3'h1;
    localparam logic [OP_W-1:0] OP_IDX_ST_TAG  = 3'h2;
    localparam logic [OP_W-1:0] OP_CREATE_DX   = 3'h3;
    localparam logic [OP_W-1:0] OP_HIT_INV     = 3'h4;
    localparam logic [OP_W-1:0] OP_HIT_WB_INV  = 3'h5;
    localparam logic [OP_W-1:0] OP_HIT_WB      = 3'h6;
    // data cache op cycle counts
    localparam logic [CNT_W-1:0] C7  = 10'h007;
    localparam logic [CNT_W-1:0] C8  = 10'h008;
    localparam logic [CNT_W-1:0] C9  = 10'h009;
    localparam logic [CNT_W-1:0] C10 = 10'h00A;
    localparam logic [CNT_W-1:0] C12 = 10'h00C;
    localparam logic [CNT_W-1:0] C13 = 10'h00D;
    localparam logic [CNT_W-1:0] C14 = 10'h00E;
    localparam logic [CNT_W-1:0] C15 = 10'h00F;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WBRET = 3'b001,
        ST_EXT   = 3'b010,
        ST_DRAIN = 3'b011,
        ST_ALIGN = 3'b100,
        ST_COUNT = 3'b101
    } seq_state_type;

    typedef enum logic [1:0] {
        JOB_NONE = 2'b00,
        JOB_IMISS = 2'b01,
        JOB_DMISS = 2'b10,
        JOB_CACHEOP = 2'b11
    } job_type;
endpackage : miss_seq_pkg
`default_nettype wire

// File: verilog/op_cycle_lut.sv
`timescale 1ns/1ps
`default_nettype none
// fixed cycle counts of primary data cache maintenance ops
module op_cycle_lut (
    // op request
    input  wire logic [miss_seq_pkg::OP_W-1:0]   i_op_code,
    input  wire logic                            i_op_hit,
    input  wire logic                            i_op_dirty,
    // result
    output logic [miss_seq_pkg::CNT_W-1:0]       o_cycles,
    output logic                                 o_fills_wb
);
    import miss_seq_pkg::*;

    // dirty lines are the only ones that load the write-back buffer
    always_comb begin
        o_cycles   = C7;
        o_fills_wb = 1'b0;
        unique case (i_op_code)
            OP_IDX_WB_INV: begin
                o_cycles   = i_op_dirty ? C12 : C10;
                o_fills_wb = i_op_dirty;
            end
            OP_IDX_LD_TAG: o_cycles = C7;
            OP_IDX_ST_TAG: o_cycles = C8;
            OP_CREATE_DX: begin
                o_cycles   = i_op_hit ? C10 : (i_op_dirty ? C15 : C13);
                o_fills_wb = !i_op_hit && i_op_dirty;
            end
            OP_HIT_INV: o_cycles = i_op_hit ? C9 : C7;
            OP_HIT_WB_INV: begin
                o_cycles   = !i_op_hit ? C7 : (i_op_dirty ? C14 : C12);
                o_fills_wb = i_op_hit && i_op_dirty;
            end
            OP_HIT_WB: begin
                o_cycles   = !i_op_hit ? C7 : (i_op_dirty ? C14 : C10);
                o_fills_wb = i_op_hit && i_op_dirty;
            end
            default: begin
                o_cycles   = C7;
                o_fills_wb = 1'b0;
            end
        endcase
    end
endmodule : op_cycle_lut
`default_nettype wire

// File: verilog/sys_clk_phase.sv
`timescale 1ns/1ps
`default_nettype none
// divides the processor clock into the system clock phase
module sys_clk_phase (
    // clock and reset
    input  wire logic                               i_sys_clk,
    input  wire logic                               i_srst,
    // ratio
    input  wire logic [miss_seq_pkg::RATIO_W-1:0]   i_clock_ratio,
    // phase
    output logic                                    o_sys_edge,
    output logic [miss_seq_pkg::RATIO_W-1:0]        o_phase
);
    import miss_seq_pkg::*;

    typedef struct packed {
        logic [RATIO_W-1:0] ph;
    } st_type;

    st_type s_q;
    st_type s_d;
    logic [RATIO_W-1:0] ratio_c;

    // clamp so an illegal ratio still gives a sane divider
    always_comb begin
        ratio_c = i_clock_ratio;
        if (i_clock_ratio < RATIO_W'(RATIO_MIN)) begin
            ratio_c = RATIO_W'(RATIO_MIN);
        end else if (i_clock_ratio > RATIO_W'(RATIO_MAX)) begin
            ratio_c = RATIO_W'(RATIO_MAX);
        end
        s_d = s_q;
        if (s_q.ph >= ratio_c - RATIO_W'(1)) begin
            s_d.ph = '0;
        end else begin
            s_d.ph = s_q.ph + RATIO_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sys_edge = (s_q.ph == '0);
    assign o_phase    = s_q.ph;
endmodule : sys_clk_phase
`default_nettype wire
